// [include/mcg_pkg.sv]
// Package for the processor clock-domain gating block.
// Assumes a single 125 MHz clock and an AXI4-Lite register slave.
package mcg_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] MCG_OFS_IDLE_SEL = 8'h00;
    localparam logic [7:0] MCG_OFS_CLK_EN = 8'h04;
    localparam logic [7:0] MCG_OFS_CTRL = 8'h08;
    localparam logic [7:0] MCG_OFS_STATUS = 8'h0C;

    // ==========================================================
    // Reset values
    localparam logic [15:0] MCG_RST_IDLE_SEL = 16'h0000;
    localparam logic [15:0] MCG_RST_CLK_EN = 16'h0100;
    localparam logic [15:0] MCG_RST_CTRL = 16'h0000;

    // ==========================================================
    // Idle-entry select fields
    localparam int MCG_B_WDT_IDLE = 0;
    localparam int MCG_B_REF_IDLE = 1;
    localparam int MCG_B_PER_IDLE = 2;
    localparam logic [15:0] MCG_IDLE_SEL_MASK = 16'h003F;

    // ==========================================================
    // Domain clock enable fields
    localparam int MCG_B_WDT_EN = 0;
    localparam int MCG_B_REF_EN = 1;
    localparam int MCG_B_PER_EN = 2;
    localparam int MCG_B_LCD_EN = 3;
    localparam int MCG_B_LB_EN = 4;
    localparam int MCG_B_HPI_EN = 6;
    localparam int MCG_B_TIM_EN = 7;
    localparam int MCG_B_DMA_REQ = 8;
    localparam int MCG_B_GPIO_EN = 9;
    localparam logic [15:0] MCG_CLK_EN_MASK = 16'h07FF;

    // ==========================================================
    // Control fields
    localparam int MCG_B_SET_IDLE = 0;
    localparam int MCG_B_IF_IDLE = 1;
    localparam int MCG_B_TIM_IDLE = 2;
    localparam logic [15:0] MCG_CTRL_MASK = 16'h0007;

    // ==========================================================
    // Gated domains, index into the run vector, then the status idle and watchdog bits
    localparam int MCG_NDOM = 9;
    localparam int MCG_D_WDT = 0;
    localparam int MCG_D_REF = 1;
    localparam int MCG_D_PER = 2;
    localparam int MCG_D_LCD = 3;
    localparam int MCG_D_LB = 4;
    localparam int MCG_D_HPI = 5;
    localparam int MCG_D_TIM = 6;
    localparam int MCG_D_DMA = 7;
    localparam int MCG_D_GPIO = 8;
    localparam int MCG_B_ST_IDLE = 9;
    localparam int MCG_B_ST_WDOG = 10;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] MCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] MCG_RESP_SLVERR = 2'h2;
endpackage : mcg_pkg

// [rtl/mcg_run_gate.sv]
// Registered run-enable generator, one bit per gated clock domain.
// Assumes the downstream clock gate cells sample these levels.
`timescale 1ns/1ps
module mcg_run_gate
    import mcg_pkg::*;
#(
    parameter int N = MCG_NDOM
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic idle,
    input wire logic [N-1:0] enable,
    input wire logic [N-1:0] idle_sel,
    input wire logic [N-1:0] keep_on,
    output logic [N-1:0] run
);
    logic [N-1:0] next_run;

    // ==========================================================
    // Run when enabled and not stopped by idle entry
    always_comb
    begin
        next_run = keep_on | (enable & ~({N{idle}} & idle_sel));
    end

    // Levels change only at clock edges, so gate cells see no glitch
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run <= '0;
        end
        else
        begin
            run <= next_run;
        end
    end
endmodule : mcg_run_gate

// [rtl/mcg_top.sv]
// Clock-domain gating for the processor peripheral clock domains.
// Assumes AXI4-Lite register access, one clock, processor idle inputs
// and a watchdog-mode level from the timer on the same clock.
//
// Contract
// - Idle-select bit 2: peripheral clock stops on processor idle when 1.
// - Idle-select bit 1: OS timer and reference clock stop on idle when 1.
// - Idle-select bit 0: timer/watchdog clock stops on idle when 1.
// - Watchdog mode keeps watchdog clock running regardless of its bits.
// - Enable bits gate their domains whether processor is idle or not.
// - Enable bit 9 runs the GPIO clock, reset 0.
// - Bit 8 reset 1: DMA clock on request; else idle-stopped by interface select.
// - Enable bit 7 runs timer clock, subject to timer idle select.
// - Enable bit 6 runs the host port interface clock.
// - Enable bits 15 to 11 read undefined, writes ignored.
// - Enable bit 4 runs the local bus clock.
// - Enable bit 3 runs the display controller clock.
// - Enable bit 2 runs peripheral clock, subject to idle stop.
// - Enable bit 1 runs OS timer and reference clocks, subject to idle select.
// - Processor idle is the set-idle bit or wait-for-interrupt.
// - Enable bit 0 runs watchdog clock, subject to watchdog idle select.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module mcg_top
    import mcg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic wfi_active,
    input wire logic irq_request,
    input wire logic watchdog_mode,
    input wire logic dma_request,
    output logic proc_idle,
    output logic watchdog_clk_run,
    output logic refclk_run,
    output logic periph_clk_run,
    output logic display_ctrl_clk_run,
    output logic local_bus_clk_run,
    output logic host_port_clk_run,
    output logic timer_clk_run,
    output logic dma_clk_run,
    output logic gpio_clk_run
);
    // ==========================================================
    // Helper functions
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == MCG_OFS_IDLE_SEL) || (addr == MCG_OFS_CLK_EN) ||
                    (addr == MCG_OFS_CTRL) || (addr == MCG_OFS_STATUS);
    endfunction : is_mapped

    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [15:0] mask
    );
        logic [15:0] val;
        val = old_val;
        if (strb[0])
        begin
            val[7:0] = wdata[7:0];
        end
        if (strb[1])
        begin
            val[15:8] = wdata[15:8];
        end
        merge16 = (val & mask) | (old_val & ~mask);
    endfunction : merge16

    // ==========================================================
    // Bus state
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic [7:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;

    // ==========================================================
    // Register state
    logic [15:0] idle_sel_reg;
    logic [15:0] clk_en_reg;
    logic [15:0] ctrl_reg;
    logic [15:0] next_idle_sel_reg;
    logic [15:0] next_clk_en_reg;
    logic [15:0] next_ctrl_reg;
    logic next_proc_idle;
    logic [MCG_NDOM-1:0] run;
    logic [MCG_NDOM-1:0] dom_en;
    logic [MCG_NDOM-1:0] dom_idle_sel;
    logic [MCG_NDOM-1:0] dom_keep;

    // ==========================================================
    // Read mux
    function automatic logic [31:0] read_word(
        input logic [7:0] addr,
        input logic [15:0] sel_r,
        input logic [15:0] en_r,
        input logic [15:0] ctl_r,
        input logic [MCG_NDOM-1:0] run_r,
        input logic idle_r,
        input logic wdog_r
    );
        logic [31:0] word;
        word = 32'h0000_0000;
        unique case (addr)
            MCG_OFS_IDLE_SEL: word[15:0] = sel_r & MCG_IDLE_SEL_MASK;
            MCG_OFS_CLK_EN: word[15:0] = en_r & MCG_CLK_EN_MASK;
            MCG_OFS_CTRL: word[15:0] = ctl_r & MCG_CTRL_MASK;
            MCG_OFS_STATUS:
            begin
                word[MCG_NDOM-1:0] = run_r;
                word[MCG_B_ST_IDLE] = idle_r;
                word[MCG_B_ST_WDOG] = wdog_r;
            end
            default: word = 32'h0000_0000;
        endcase
        read_word = word;
    endfunction : read_word

    // ==========================================================
    // AXI4-Lite write and read channels
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        do_write = aw_held && w_held && !s_axi_bvalid;
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (do_write)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr) ? MCG_RESP_OKAY : MCG_RESP_SLVERR;
        end
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
        if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rdata = read_word(s_axi_araddr, idle_sel_reg, clk_en_reg, ctrl_reg,
                                   run, proc_idle, watchdog_mode);
            next_rresp = is_mapped(s_axi_araddr) ? MCG_RESP_OKAY : MCG_RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= MCG_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= MCG_RESP_OKAY;
        end
        else
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ==========================================================
    // Software registers and processor idle
    always_comb
    begin
        next_idle_sel_reg = idle_sel_reg;
        next_clk_en_reg = clk_en_reg;
        next_ctrl_reg = ctrl_reg;
        // Interrupt wakes the processor by clearing set-idle
        if (irq_request)
        begin
            next_ctrl_reg[MCG_B_SET_IDLE] = 1'b0;
        end
        if (do_write)
        begin
            unique case (aw_addr)
                MCG_OFS_IDLE_SEL:
                    next_idle_sel_reg = merge16(idle_sel_reg, w_data, w_strb,
                                                MCG_IDLE_SEL_MASK);
                MCG_OFS_CLK_EN:
                    next_clk_en_reg = merge16(clk_en_reg, w_data, w_strb,
                                              MCG_CLK_EN_MASK);
                MCG_OFS_CTRL:
                    next_ctrl_reg = merge16(next_ctrl_reg, w_data, w_strb, MCG_CTRL_MASK);
                default:
                    next_ctrl_reg = next_ctrl_reg;
            endcase
        end
        next_proc_idle = next_ctrl_reg[MCG_B_SET_IDLE] | wfi_active;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            idle_sel_reg <= MCG_RST_IDLE_SEL;
            clk_en_reg <= MCG_RST_CLK_EN;
            ctrl_reg <= MCG_RST_CTRL;
            proc_idle <= 1'b0;
        end
        else
        begin
            idle_sel_reg <= next_idle_sel_reg;
            clk_en_reg <= next_clk_en_reg;
            ctrl_reg <= next_ctrl_reg;
            proc_idle <= next_proc_idle;
        end
    end

    // ==========================================================
    // Per-domain enable, idle select and override
    always_comb
    begin
        dom_en = '0;
        dom_idle_sel = '0;
        dom_keep = '0;
        dom_en[MCG_D_WDT] = clk_en_reg[MCG_B_WDT_EN];
        dom_idle_sel[MCG_D_WDT] = idle_sel_reg[MCG_B_WDT_IDLE];
        dom_keep[MCG_D_WDT] = watchdog_mode;
        dom_en[MCG_D_REF] = clk_en_reg[MCG_B_REF_EN];
        dom_idle_sel[MCG_D_REF] = idle_sel_reg[MCG_B_REF_IDLE];
        dom_en[MCG_D_PER] = clk_en_reg[MCG_B_PER_EN];
        // Either select stops the peripheral clock at idle
        dom_idle_sel[MCG_D_PER] = idle_sel_reg[MCG_B_PER_IDLE]
                                  | ctrl_reg[MCG_B_TIM_IDLE];
        dom_en[MCG_D_LCD] = clk_en_reg[MCG_B_LCD_EN];
        dom_en[MCG_D_LB] = clk_en_reg[MCG_B_LB_EN];
        dom_en[MCG_D_HPI] = clk_en_reg[MCG_B_HPI_EN];
        dom_en[MCG_D_TIM] = clk_en_reg[MCG_B_TIM_EN];
        dom_idle_sel[MCG_D_TIM] = ctrl_reg[MCG_B_TIM_IDLE];
        dom_en[MCG_D_GPIO] = clk_en_reg[MCG_B_GPIO_EN];
        if (clk_en_reg[MCG_B_DMA_REQ])
        begin
            dom_en[MCG_D_DMA] = dma_request;
        end
        else
        begin
            dom_en[MCG_D_DMA] = 1'b1;
            dom_idle_sel[MCG_D_DMA] = ctrl_reg[MCG_B_IF_IDLE];
        end
    end

    mcg_run_gate #(
        .N(MCG_NDOM)
    ) u_run_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .idle(proc_idle),
        .enable(dom_en),
        .idle_sel(dom_idle_sel),
        .keep_on(dom_keep),
        .run(run)
    );

    // ==========================================================
    // Domain run outputs, each a flip-flop in the gate module
    assign watchdog_clk_run = run[MCG_D_WDT];
    assign refclk_run = run[MCG_D_REF];
    assign periph_clk_run = run[MCG_D_PER];
    assign display_ctrl_clk_run = run[MCG_D_LCD];
    assign local_bus_clk_run = run[MCG_D_LB];
    assign host_port_clk_run = run[MCG_D_HPI];
    assign timer_clk_run = run[MCG_D_TIM];
    assign dma_clk_run = run[MCG_D_DMA];
    assign gpio_clk_run = run[MCG_D_GPIO];
endmodule : mcg_top

// [dv/mcg_top_checker.sv]
// Checker for the clock-domain gating top: run outputs against a shadow of the
// enable register. Assumes it is bound to mcg_top with one write under way at a time.
`timescale 1ns/1ps
module mcg_top_checker
    import mcg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic wfi_active,
    input wire logic watchdog_mode,
    input wire logic dma_request,
    input wire logic proc_idle,
    input wire logic watchdog_clk_run,
    input wire logic refclk_run,
    input wire logic periph_clk_run,
    input wire logic display_ctrl_clk_run,
    input wire logic local_bus_clk_run,
    input wire logic host_port_clk_run,
    input wire logic timer_clk_run,
    input wire logic dma_clk_run,
    input wire logic gpio_clk_run
);
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================================
    // Enable shadow, committed on the first cycle of each write response
    logic [7:0] aw_s, next_aw;
    logic [15:0] wd_s, next_wd, en_s, next_en;
    logic [1:0] ws_s, next_ws;
    logic bv_q;
    always_comb
    begin
        next_aw = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_s;
        next_wd = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[15:0] : wd_s;
        next_ws = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[1:0] : ws_s;
        next_en = en_s;
        if (s_axi_bvalid && !bv_q && s_axi_bresp == MCG_RESP_OKAY && aw_s == MCG_OFS_CLK_EN)
        begin
            if (ws_s[0])
                next_en[7:0] = wd_s[7:0];
            if (ws_s[1])
                next_en[10:8] = wd_s[10:8];
        end
    end
    always_ff @(posedge aclk)
    begin
        aw_s <= next_aw;
        wd_s <= next_wd;
        ws_s <= next_ws;
        bv_q <= aresetn && s_axi_bvalid;
        en_s <= aresetn ? next_en : MCG_RST_CLK_EN;
    end
    // ==========================================================
    // Assertions
    wdog_force_a: assert property (watchdog_mode |=> watchdog_clk_run)
        else $error("watchdog clock stopped in watchdog mode");
    idle_entry_a: assert property (wfi_active |=> proc_idle)
        else $error("idle not flagged after wait-for-interrupt");
    gpio_en_a: assert property (gpio_clk_run == en_s[MCG_B_GPIO_EN])
        else $error("gpio run differs from enable");
    hpi_en_a: assert property (host_port_clk_run == en_s[MCG_B_HPI_EN])
        else $error("host port run differs from enable");
    lbus_en_a: assert property (local_bus_clk_run == en_s[MCG_B_LB_EN])
        else $error("local bus run differs from enable");
    lcd_en_a: assert property (display_ctrl_clk_run == en_s[MCG_B_LCD_EN])
        else $error("display run differs from enable");
    timer_off_a: assert property (!en_s[MCG_B_TIM_EN] |-> !timer_clk_run)
        else $error("timer clock runs while disabled");
    periph_off_a: assert property (!en_s[MCG_B_PER_EN] |-> !periph_clk_run)
        else $error("peripheral clock runs while disabled");
    ref_off_a: assert property (!en_s[MCG_B_REF_EN] |-> !refclk_run)
        else $error("reference clock runs while disabled");
    wdt_off_a: assert property (!en_s[0] && !$past(watchdog_mode) |-> !watchdog_clk_run)
        else $error("watchdog clock runs while disabled");
    dma_req_a: assert property (en_s[8] && $past(aresetn) |-> dma_clk_run == $past(dma_request))
        else $error("dma clock does not follow its request");
    cover property (watchdog_mode && !en_s[MCG_B_WDT_EN]);
    cover property ($rose(proc_idle));
    cover property (en_s[MCG_B_DMA_REQ] && dma_request);
    cover property ($rose(gpio_clk_run));
endmodule : mcg_top_checker

bind mcg_top mcg_top_checker u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .wfi_active(wfi_active), .watchdog_mode(watchdog_mode), .dma_request(dma_request),
    .proc_idle(proc_idle), .watchdog_clk_run(watchdog_clk_run), .refclk_run(refclk_run),
    .periph_clk_run(periph_clk_run), .display_ctrl_clk_run(display_ctrl_clk_run),
    .local_bus_clk_run(local_bus_clk_run), .host_port_clk_run(host_port_clk_run),
    .timer_clk_run(timer_clk_run), .dma_clk_run(dma_clk_run), .gpio_clk_run(gpio_clk_run)
);

// [dv/mcg_top_tb_top.sv]
// Testbench for the clock-domain gating top: table of gating cases, then reset,
// register map and idle wake tests. Assumes the bound checker file is compiled too.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module mcg_top_tb_top
    import mcg_pkg::*;
;
    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] en;
        logic [15:0] ctl;
        logic wfi;
        logic wdog;
        logic dreq;
        logic [8:0] run;
    } mcg_row_t;
    localparam int NROW = 9;
    // Run vector order: gpio dma tim hpi lb lcd per ref wdt
    mcg_row_t rows [NROW] = '{
        '{16'h0007, 16'h02DF, 16'h0000, 1'h0, 1'h0, 1'h0, 9'h1FF},
        '{16'h0007, 16'h02DF, 16'h0006, 1'h1, 1'h0, 1'h0, 9'h138},
        '{16'h0000, 16'h02DF, 16'h0000, 1'h1, 1'h0, 1'h0, 9'h1FF},
        '{16'h0004, 16'h02DF, 16'h0001, 1'h0, 1'h0, 1'h0, 9'h1FB},
        '{16'h0000, 16'h02DF, 16'h0005, 1'h0, 1'h0, 1'h0, 9'h1BB},
        '{16'h0001, 16'h0000, 16'h0000, 1'h1, 1'h1, 1'h0, 9'h081},
        '{16'h0000, 16'h0100, 16'h0000, 1'h0, 1'h0, 1'h1, 9'h080},
        '{16'h0002, 16'h0202, 16'h0000, 1'h1, 1'h0, 1'h0, 9'h180},
        '{16'h0000, 16'h0100, 16'h0000, 1'h0, 1'h0, 1'h0, 9'h000}
    };
    logic aclk, aresetn, awvalid, wvalid, arvalid, wfi, irq, wdog, dreq;
    logic [7:0] awaddr, araddr;
    logic [15:0] wdata;
    logic [31:0] rdat;
    logic [3:0] wstrb;
    logic [1:0] rsp;
    wire logic awready, wready, bvalid, arready, rvalid, pidle;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [8:0] run_v;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    mcg_top u_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata({16'h0000, wdata}), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .wfi_active(wfi), .irq_request(irq), .watchdog_mode(wdog), .dma_request(dreq),
        .proc_idle(pidle), .watchdog_clk_run(run_v[0]), .refclk_run(run_v[1]),
        .periph_clk_run(run_v[2]), .display_ctrl_clk_run(run_v[3]),
        .local_bus_clk_run(run_v[4]), .host_port_clk_run(run_v[5]),
        .timer_clk_run(run_v[6]), .dma_clk_run(run_v[7]), .gpio_clk_run(run_v[8])
    );
    // ==========================================================
    // Bus tasks and closing report
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        awaddr <= a;
        awvalid <= 1'h1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
        end
        while (bvalid !== 1'h1);
        rsp = bresp;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
        end
        while (rvalid !== 1'h1);
        rdat = rdata;
        rsp = rresp;
    endtask : rd
    task automatic results();
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    initial
    begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            results();
        end
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, arvalid, wfi, irq, wdog, dreq} <= 8'h00;
        {awaddr, araddr, wdata, wstrb} <= 36'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        for (int i = 0; i < NROW; i++)
        begin
            wfi <= rows[i].wfi;
            wdog <= rows[i].wdog;
            dreq <= rows[i].dreq;
            wr(MCG_OFS_IDLE_SEL, rows[i].sel, 4'hF);
            wr(MCG_OFS_CLK_EN, rows[i].en, 4'hF);
            wr(MCG_OFS_CTRL, rows[i].ctl, 4'hF);
            repeat (3) @(posedge aclk);
            `CHK("run", rows[i].run, run_v)
            rd(MCG_OFS_STATUS);
            `CHK("status run", rows[i].run, rdat[8:0])
        end
        // Reset in mid-run, then reset values
        aresetn <= 1'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        `CHK("run after reset", 9'h000, run_v)
        rd(MCG_OFS_IDLE_SEL);
        `CHK("select reset", 16'h0000, rdat[15:0])
        rd(MCG_OFS_CLK_EN);
        `CHK("enable reset", 16'h0100, rdat[15:0])
        // Reserved select bits 5 to 3 and enable bits 10 and 5 are written as zero
        wr(MCG_OFS_IDLE_SEL, 16'h0007, 4'hF);
        rd(MCG_OFS_IDLE_SEL);
        `CHK("select rw", 16'h0007, rdat[15:0])
        wr(MCG_OFS_CLK_EN, 16'hFBDF, 4'hF);
        rd(MCG_OFS_CLK_EN);
        `CHK("enable rw", 16'h03DF, rdat[15:0])
        wr(MCG_OFS_CLK_EN, 16'h0000, 4'h2);
        rd(MCG_OFS_CLK_EN);
        `CHK("enable strobe", 16'h00DF, rdat[15:0])
        wr(8'h10, 16'h1234, 4'hF);
        `CHK("unmapped write", MCG_RESP_SLVERR, rsp)
        rd(8'h10);
        `CHK("unmapped read", MCG_RESP_SLVERR, rsp)
        `CHK("unmapped data", 32'h0, rdat)
        // Set-idle entry, watchdog override, then wake by interrupt
        wr(MCG_OFS_CTRL, 16'h0001, 4'hF);
        repeat (3) @(posedge aclk);
        `CHK("idle", 1'h1, pidle)
        `CHK("idle stopped", 3'h0, run_v[2:0])
        wdog <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("watchdog kept", 1'h1, run_v[0])
        irq <= 1'h1;
        @(posedge aclk);
        irq <= 1'h0;
        repeat (3) @(posedge aclk);
        `CHK("woken", 1'h0, pidle)
        `CHK("woken run", 3'h7, run_v[2:0])
        results();
    end
endmodule : mcg_top_tb_top
